/* core/rso_pkg.sv */
package rso_pkg;

    // Clock rate
    localparam int unsigned CLK_HZ            = 100_000_000;
    // Reset filter time in microseconds; plain default
    localparam int unsigned FILTER_TIME_US    = 10;
    // Reset delay time in microseconds; plain default
    localparam int unsigned DELAY_TIME_US     = 10;
    // Times convert to whole cycles; cycles per microsecond round down
    localparam int unsigned FILTER_CYCLES     = (FILTER_TIME_US * (CLK_HZ / 1_000_000));
    localparam int unsigned DELAY_CYCLES      = (DELAY_TIME_US * (CLK_HZ / 1_000_000));
    localparam int unsigned CNT_W             = 16;

    // Mode field value that commands a soft reset
    localparam logic [1:0]  MODE_SOFT_RESET   = 2'h3;
    // Threshold select after reset: lowest
    localparam logic [1:0]  THRESH_RESET      = 2'h0;
    // Soft reset drives output after reset
    localparam logic        SRDO_RESET        = 1'b1;

    // Device operating states seen by this block
    typedef enum logic [2:0]
    {
        RSO_INIT,
        RSO_NORMAL,
        RSO_STOP,
        RSO_SLEEP,
        RSO_RESTART,
        RSO_FAILSAFE
    } rso_state_e;

endpackage

/* core/rso_cmd_if.sv */
`timescale 1ns/1ps
// Soft reset command carried from the frame decoder to the sequencer
interface rso_cmd_if;
    logic       soft_req;
    modport src (output soft_req);
    modport dst (input  soft_req);
endinterface

/* core/rso_frame.sv */
`timescale 1ns/1ps
// Decodes a finished write frame into a soft reset request pulse
module rso_frame
(
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   frame_end,
    input  wire logic   frame_valid,
    input  wire logic   frame_write,
    input  wire logic [1:0] frame_mode,
    input  wire logic   mode_reg_hit,
    rso_cmd_if.src      cmd
);

    ////////////////////////////////////////////////////////////////////////////
    // Only a complete, well formed write to the mode field counts
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cmd.soft_req <= 1'b0;
        else
            cmd.soft_req <= frame_end && frame_valid && frame_write && mode_reg_hit
                            && (frame_mode == rso_pkg::MODE_SOFT_RESET); // RULE_11
    end

endmodule // rso_frame

/* core/rso_reset_out.sv */
`timescale 1ns/1ps
// Behaviour
// RULE_01 - Event pulls output low after filter time, held through event plus delay
// RULE_02 - At power-up output held low until regulator good plus delay time
// RULE_03 - Watchdog trigger failure is a reset event
// RULE_04 - Undervoltage threshold selectable by setting; lowest after reset
// RULE_05 - Output actively pulled low when regulator above 1V and supply above POR
// RULE_06 - Controller requests soft reset by writing mode field value 11
// RULE_07 - Soft reset returns device to init and restores register defaults
// RULE_08 - Default configuration asserts output on soft reset with same delay; code does so only from RO_HIGH, the other sequencer states ignore it
// RULE_09 - Alternative configuration performs soft reset without asserting output
// RULE_10 - Soft reset accepted only in normal or stop state
// RULE_11 - Soft reset takes effect at chip select release of valid write frame
module rso_reset_out
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       supply_por_ok,
    input  wire logic       regulator_above_1v,
    input  wire logic       regulator_undervoltage,
    input  wire logic       watchdog_fail,
    input  wire rso_pkg::rso_state_e dev_state,
    input  wire logic       frame_end,
    input  wire logic       frame_valid,
    input  wire logic       frame_write,
    input  wire logic       mode_reg_hit,
    input  wire logic [1:0] frame_mode,
    input  wire logic       cfg_write,
    input  wire logic [1:0] cfg_thresh,
    input  wire logic       cfg_srdo,
    output logic            reset_out_pin,
    output logic            reset_out_oe,
    output logic            soft_reset_pulse,
    output logic [1:0]      undervoltage_reset_threshold,
    output logic            soft_reset_drives_output
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Soft reset command decode
    rso_cmd_if cmd ();
    rso_frame u_frame
    (
        .clk          (clk),
        .rst_n        (rst_n),
        .frame_end    (frame_end),
        .frame_valid  (frame_valid),
        .frame_write  (frame_write),
        .frame_mode   (frame_mode),
        .mode_reg_hit (mode_reg_hit),
        .cmd          (cmd)
    );

    // Accepted only in normal or stop; ignored elsewhere with no change
    logic soft_go;
    assign soft_go = cmd.soft_req &&
                     (dev_state == rso_pkg::RSO_NORMAL || dev_state == rso_pkg::RSO_STOP); // RULE_10

    ////////////////////////////////////////////////////////////////////////////
    // Settings; soft reset restores defaults and wins over a same-cycle write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            undervoltage_reset_threshold <= rso_pkg::THRESH_RESET; // RULE_04
            soft_reset_drives_output     <= rso_pkg::SRDO_RESET;
        end
        else if (soft_go)
        begin
            undervoltage_reset_threshold <= rso_pkg::THRESH_RESET; // RULE_07
            soft_reset_drives_output     <= rso_pkg::SRDO_RESET;   // RULE_07
        end
        else if (cfg_write)
        begin
            undervoltage_reset_threshold <= cfg_thresh; // RULE_04
            soft_reset_drives_output     <= cfg_srdo;
        end
    end

    // One-cycle pulse to the rest of the chip: go to init, registers default
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            soft_reset_pulse <= 1'b0;
        else
            soft_reset_pulse <= soft_go; // RULE_07
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output sequencer
    typedef enum logic [1:0] { RO_POWERUP, RO_HIGH, RO_FILTER, RO_LOW } rso_ro_e;
    rso_ro_e                  ro_state;
    logic [rso_pkg::CNT_W-1:0] cnt;
    logic                     event_now;
    // Undervoltage comparator already uses the selected threshold
    assign event_now = regulator_undervoltage || watchdog_fail; // RULE_03

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ro_state <= RO_POWERUP;
            cnt      <= '0;
        end
        else
        begin
            unique case (ro_state)
                RO_POWERUP:
                    // Regulator not yet good: stay low, then run delay
                    if (regulator_undervoltage)
                        cnt <= '0; // RULE_02
                    else if (cnt == rso_pkg::CNT_W'(rso_pkg::DELAY_CYCLES - 1))
                    begin
                        ro_state <= RO_HIGH; // RULE_02
                        cnt      <= '0;
                    end
                    else
                        cnt <= cnt + 1'b1;
                RO_HIGH:
                    if (soft_go && soft_reset_drives_output) // RULE_09
                    begin
                        ro_state <= RO_LOW; // RULE_08
                        cnt      <= '0;
                    end
                    else if (event_now)
                    begin
                        ro_state <= RO_FILTER; // RULE_01
                        cnt      <= '0;
                    end
                RO_FILTER:
                    // Short glitches do not reach the pin
                    if (!event_now)
                        ro_state <= RO_HIGH;
                    else if (cnt == rso_pkg::CNT_W'(rso_pkg::FILTER_CYCLES - 1))
                    begin
                        ro_state <= RO_LOW; // RULE_01
                        cnt      <= '0;
                    end
                    else
                        cnt <= cnt + 1'b1;
                RO_LOW:
                    // Delay restarts while the event persists
                    if (event_now)
                        cnt <= '0; // RULE_01
                    else if (cnt == rso_pkg::CNT_W'(rso_pkg::DELAY_CYCLES - 1))
                    begin
                        ro_state <= RO_HIGH; // RULE_01
                        cnt      <= '0;
                    end
                    else
                        cnt <= cnt + 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drive; open drain low, pull-up gives the high level
    logic next_low;
    assign next_low = (ro_state == RO_POWERUP) || (ro_state == RO_LOW);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reset_out_pin <= 1'b0;
            reset_out_oe  <= 1'b0;
        end
        else
        begin
            reset_out_pin <= 1'b0;
            // Active pull-down only where the supplies allow it
            reset_out_oe  <= next_low && regulator_above_1v && supply_por_ok; // RULE_05
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // Cycles spent filtering, counted apart from the sequencer so a broken count shows
    logic [rso_pkg::CNT_W-1:0] filt_run;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            filt_run <= '0;
        else if (ro_state == RO_FILTER)
            filt_run <= filt_run + 1'b1;
        else
            filt_run <= '0;
    end
    chk_filter_reach: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        (ro_state == RO_FILTER && event_now && filt_run == rso_pkg::CNT_W'(rso_pkg::FILTER_CYCLES - 1))
        |=> (ro_state == RO_LOW))
        else $error("Output not asserted after filter time");
    chk_filter_early: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        (ro_state == RO_FILTER && filt_run != rso_pkg::CNT_W'(rso_pkg::FILTER_CYCLES - 1))
        |=> (ro_state != RO_LOW))
        else $error("Output asserted before filter time");
    chk_low_holds: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        (ro_state == RO_LOW && event_now) |=> (ro_state == RO_LOW))
        else $error("Output released during event");
    chk_powerup_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        (ro_state == RO_POWERUP && regulator_undervoltage) |=> (ro_state == RO_POWERUP))
        else $error("Released before regulator good");
    chk_wdog_event: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
        (ro_state == RO_HIGH && watchdog_fail && !soft_go) |=> (ro_state == RO_FILTER))
        else $error("Watchdog failure ignored");
    chk_thresh_default: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        soft_go |=> (undervoltage_reset_threshold == rso_pkg::THRESH_RESET))
        else $error("Threshold not default after soft reset");
    chk_pull_low: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        (next_low && regulator_above_1v && supply_por_ok) |=> reset_out_oe)
        else $error("Output not pulled low");
    chk_soft_pulse: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
        soft_go |=> soft_reset_pulse)
        else $error("Soft reset not executed");
    chk_soft_asserts: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
        (soft_go && soft_reset_drives_output && ro_state == RO_HIGH) |=> (ro_state == RO_LOW))
        else $error("Soft reset did not assert output");
    chk_soft_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
        (soft_go && !soft_reset_drives_output && ro_state == RO_HIGH && !event_now) |=> (ro_state == RO_HIGH))
        else $error("Soft reset asserted output when disabled");
    chk_state_gate: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
        (cmd.soft_req && dev_state != rso_pkg::RSO_NORMAL && dev_state != rso_pkg::RSO_STOP) |=> !soft_reset_pulse)
        else $error("Soft reset accepted in wrong state");
    chk_frame_only: assert property (@(posedge clk) disable iff (!rst_n) // RULE_11
        !(frame_end && frame_valid && frame_write && mode_reg_hit) |=> !cmd.soft_req)
        else $error("Soft reset without valid frame");

endmodule // rso_reset_out

/* dv/rso_mcu_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Controller side: frame source toward the block, reset pin observer
module rso_mcu_model
(
    input  wire logic   clk,
    input  wire logic   reset_out_pin,
    input  wire logic   reset_out_oe,
    output logic        frame_end = 1'b0,
    output logic        frame_valid = 1'b0,
    output logic        frame_write = 1'b0,
    output logic        mode_reg_hit = 1'b0,
    output logic [1:0]  frame_mode = 2'h0,
    output logic        pin_level
);
    // Integrated pull-up: pin is high unless the block sinks it
    assign pin_level = reset_out_oe ? reset_out_pin : 1'b1;

    // One write frame closed by chip select release; fields then show garbage
    task automatic send(input logic [1:0] mode, input logic ok);
        @(posedge clk);
        #1;
        frame_mode = mode;
        frame_valid = ok;
        frame_write = 1'b1;
        mode_reg_hit = 1'b1;
        frame_end = 1'b1;
        @(posedge clk);
        #1;
        frame_end = 1'b0;
        frame_mode = ~mode;
        frame_valid = ~ok;
    endtask
endmodule // rso_mcu_model

/* dv/rso_reset_out_bench.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module rso_reset_out_bench;
    logic                clk = 1'b0;
    logic                rstn = 1'b0;
    logic                por_ok = 1'b1;
    logic                above_1v = 1'b1;
    logic                uv = 1'b0;
    logic                wd = 1'b0;
    logic                cfg_wr = 1'b0;
    logic [1:0]          cfg_thr = 2'h0;
    logic                cfg_sd = 1'b0;
    rso_pkg::rso_state_e st = rso_pkg::RSO_NORMAL;
    logic                pin, oe, pulse, sdo, fe, fv, fw, hit, lvl;
    logic [1:0]          thr, fm;
    int                  miscompares = 0;
    int                  tests_run = 0;

    rso_reset_out rso_reset_out_i (.clk(clk), .rstn(rstn), .supply_por_ok(por_ok), .regulator_above_1v(above_1v),
        .regulator_undervoltage(uv), .watchdog_fail(wd), .dev_state(st), .frame_end(fe), .frame_valid(fv),
        .frame_write(fw), .mode_reg_hit(hit), .frame_mode(fm), .cfg_write(cfg_wr), .cfg_thresh(cfg_thr),
        .cfg_srdo(cfg_sd), .reset_out_pin(pin), .reset_out_oe(oe), .soft_reset_pulse(pulse),
        .undervoltage_reset_threshold(thr), .soft_reset_drives_output(sdo));
    rso_mcu_model rso_mcu_model_i (.clk(clk), .reset_out_pin(pin), .reset_out_oe(oe), .frame_end(fe),
        .frame_valid(fv), .frame_write(fw), .mode_reg_hit(hit), .frame_mode(fm), .pin_level(lvl));

    // 100 MHz clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers; inputs always move 1 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Wide enough for packed setting pairs; narrower values zero extend
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: saw %b wanted %b", $time, seen, exp);
        end
    endtask
    // Bounded wait for the sink enable; too early or too late both fail
    task automatic wait_oe(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (oe !== v && n <= hi)
        begin
            cyc(1);
            n++;
        end
        if (n > hi)
        begin
            miscompares++;
            final_report;
        end
        else
            check({1'b0, n >= lo}, 2'h1);
    endtask
    task automatic count_pulse(output logic [1:0] c);
        c = 2'h0;
        repeat (6)
        begin
            cyc(1);
            c = c + {1'b0, pulse};
        end
    endtask
    task automatic cfg(input logic [1:0] t, input logic s);
        {cfg_thr, cfg_sd, cfg_wr} = {t, s, 1'b1};
        cyc(1);
        cfg_wr = 1'b0;
        cyc(1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_powerup;
        check(thr, rso_pkg::THRESH_RESET);
        check({1'b0, lvl}, 2'h1);
        rstn = 1'b1;
        cyc(5);
        check({1'b0, lvl}, 2'h0);
        check({1'b0, pin}, 2'h0);
        wait_oe(1'b0, 985, 1010);
    endtask
    // A short event must be filtered; a long one holds for event plus delay
    task automatic t_event(input logic is_wd);
        {wd, uv} = {is_wd, ~is_wd};
        cyc(500);
        {wd, uv} = 2'h0;
        check({1'b0, oe}, 2'h0);
        cyc(20);
        {wd, uv} = {is_wd, ~is_wd};
        wait_oe(1'b1, 995, 1005);
        cyc(300);
        {wd, uv} = 2'h0;
        wait_oe(1'b0, 995, 1005);
    endtask
    task automatic t_supply;
        {uv, por_ok} = 2'b10;
        cyc(1100);
        check({1'b0, oe}, 2'h0);
        {por_ok, above_1v} = 2'b10;
        cyc(5);
        check({1'b0, oe}, 2'h0);
        above_1v = 1'b1;
        wait_oe(1'b1, 0, 10);
        uv = 1'b0;
        wait_oe(1'b0, 995, 1005);
    endtask
    task automatic t_soft_off;
        logic [1:0] c;
        cfg(2'h2, 1'b0);
        check({thr, sdo} , 3'b100);
        rso_mcu_model_i.send(2'h3, 1'b1);
        count_pulse(c);
        check(c, 2'h1);
        check({1'b0, oe}, 2'h0);
        check({thr, sdo}, 3'b001);
    endtask
    task automatic t_soft_on;
        logic [1:0] c;
        st = rso_pkg::RSO_STOP;
        rso_mcu_model_i.send(2'h3, 1'b1);
        count_pulse(c);
        check(c, 2'h1);
        check({1'b0, oe}, 2'h1);
        wait_oe(1'b0, 985, 1010);
    endtask
    // Commands in other states, malformed frames and mode value 2 do nothing
    task automatic t_refused;
        logic [1:0] c;
        rso_pkg::rso_state_e bad[4] = '{rso_pkg::RSO_INIT, rso_pkg::RSO_SLEEP, rso_pkg::RSO_RESTART,
            rso_pkg::RSO_FAILSAFE};
        cfg(2'h1, 1'b1);
        foreach (bad[i])
        begin
            st = bad[i];
            rso_mcu_model_i.send(2'h3, 1'b1);
            count_pulse(c);
            check(c, 2'h0);
        end
        st = rso_pkg::RSO_NORMAL;
        rso_mcu_model_i.send(2'h3, 1'b0);
        count_pulse(c);
        check(c, 2'h0);
        rso_mcu_model_i.send(2'h2, 1'b1);
        count_pulse(c);
        check(c, 2'h0);
        check(thr, 2'h1);
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Reset held for 10 cycles, then each scenario in turn
    initial
    begin
        cyc(10);
        t_powerup;
        t_event(1'b0);
        t_event(1'b1);
        t_supply;
        t_soft_off;
        t_soft_on;
        t_refused;
        final_report;
    end
endmodule // rso_reset_out_bench
